// File: design/handler_sort_trigger_port.sv
`timescale 1ns/10ps
`default_nettype none

module handler_sort_trigger_port #(
	parameter int CONV_CYCLES   = handler_pkg::CONV_CYC,
	parameter int CALC_CYCLES   = handler_pkg::CALC_CYC,
	parameter int RESULT_CYCLES = handler_pkg::RESULT_CYC
) (
	// Clock and reset
	input  wire logic                         CLK,
	input  wire logic                         RST_B,
	// Handler pins
	input  wire logic                         EXT_TRIG,
	input  wire logic                         KEY_LOCK_B,
	output logic [handler_pkg::NUM_BINS-1:0]  SORT_BIN_B,
	output logic                              SECONDARY_FAIL_B,
	output logic                              PRIMARY_FAIL_B,
	output logic                              PRIMARY_ABOVE_LIMIT_B,
	output logic                              PRIMARY_BELOW_LIMIT_B,
	output logic                              OVERALL_FAIL_B,
	output logic                              CONVERSION_BUSY,
	output logic                              MEASUREMENT_BUSY,
	// Measurement core side
	input  wire handler_pkg::verdict_t        VERDICT,
	input  wire logic                         AUX_COMPARE_EN,
	output logic                              KEYBOARD_LOCKED,
	output logic                              CONV_START
);
	// Phase lengths must fit the shared down-counter
	if (CONV_CYCLES < 1 || CONV_CYCLES >= 2**handler_pkg::CNT_W ||
	    CALC_CYCLES < 1 || CALC_CYCLES >= 2**handler_pkg::CNT_W ||
	    RESULT_CYCLES < 1 || RESULT_CYCLES >= 2**handler_pkg::CNT_W) begin : g_bad_cycles
		$error("handler port: cycle counts out of range");
	end

	logic [1:0] pins_s;
	logic       trig_s;
	logic       trig_prev;
	logic       trig_rise;

	pin_sync #(.WIDTH(2)) u_sync (
		.clk   (CLK),
		.rst_b (RST_B),
		.din   ({EXT_TRIG, KEY_LOCK_B}),
		.dout  (pins_s)
	);
	assign trig_s    = pins_s[1];
	assign trig_rise = trig_s & ~trig_prev;

	// Active-low encoding of a verdict
	function automatic handler_pkg::result_pins_t encode(
		input handler_pkg::verdict_t v,
		input logic                  aux
	);
		handler_pkg::result_pins_t p;
		p.bin_b            = ~v.bin_pass;
		p.secondary_fail_b = ~(v.secondary_fail & aux);
		p.primary_fail_b   = ~v.primary_fail;
		p.above_b          = ~v.above_limit;
		p.below_b          = ~v.below_limit;
		p.fail_b           = ~(v.primary_fail |
			(v.secondary_fail & aux));
		return p;
	endfunction : encode

	handler_pkg::phase_t       phase, next_phase;
	logic [handler_pkg::CNT_W-1:0] cnt, next_cnt;
	handler_pkg::result_pins_t res, next_res;
	logic conv_busy, next_conv_busy;
	logic meas_busy, next_meas_busy;
	logic conv_start, next_conv_start;
	logic locked, next_locked;

	always_comb begin
		next_phase      = phase;
		next_cnt        = cnt;
		next_res        = res;
		next_conv_start = 1'b0;
		next_locked     = ~pins_s[0];
		case (phase)
			handler_pkg::IDLE: begin
				if (trig_rise) begin
					next_phase = handler_pkg::DELAY;
					next_cnt   = handler_pkg::CNT_W'(
						handler_pkg::TRIG_DELAY_CYC - 1);
				end
			end
			handler_pkg::DELAY: begin
				if (cnt == '0) begin
					next_phase      = handler_pkg::CONV;
					next_cnt        = handler_pkg::CNT_W'(CONV_CYCLES - 1);
					next_conv_start = 1'b1;
				end else begin
					next_cnt = cnt - 1'b1;
				end
			end
			handler_pkg::CONV: begin
				if (cnt == '0) begin
					next_phase = handler_pkg::CALC;
					next_cnt   = handler_pkg::CNT_W'(CALC_CYCLES - 1);
				end else begin
					next_cnt = cnt - 1'b1;
				end
			end
			handler_pkg::CALC: begin
				if (cnt == '0) begin
					next_phase = handler_pkg::SORT;
					next_cnt   = handler_pkg::CNT_W'(RESULT_CYCLES - 1);
				end else begin
					next_cnt = cnt - 1'b1;
				end
			end
			handler_pkg::SORT: begin
				if (cnt == '0) begin
					next_phase = handler_pkg::IDLE;
					next_res   = encode(VERDICT, AUX_COMPARE_EN);
				end else begin
					next_cnt = cnt - 1'b1;
				end
			end
			default: begin
				next_phase = handler_pkg::IDLE;
				next_cnt   = '0;
			end
		endcase
		next_conv_busy = (next_phase == handler_pkg::CONV);
		next_meas_busy = (next_phase != handler_pkg::IDLE);
	end

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			phase      <= handler_pkg::IDLE;
			cnt        <= '0;
			res        <= '1;
			conv_busy  <= 1'b0;
			meas_busy  <= 1'b0;
			conv_start <= 1'b0;
			locked     <= 1'b0;
			trig_prev  <= 1'b1;
		end else begin
			phase      <= next_phase;
			cnt        <= next_cnt;
			res        <= next_res;
			conv_busy  <= next_conv_busy;
			meas_busy  <= next_meas_busy;
			conv_start <= next_conv_start;
			locked     <= next_locked;
			trig_prev  <= trig_s;
		end
	end

	assign SORT_BIN_B            = res.bin_b;
	assign SECONDARY_FAIL_B      = res.secondary_fail_b;
	assign PRIMARY_FAIL_B        = res.primary_fail_b;
	assign PRIMARY_ABOVE_LIMIT_B = res.above_b;
	assign PRIMARY_BELOW_LIMIT_B = res.below_b;
	assign OVERALL_FAIL_B        = res.fail_b;
	assign CONVERSION_BUSY       = conv_busy;
	assign MEASUREMENT_BUSY      = meas_busy;
	assign CONV_START            = conv_start;
	assign KEYBOARD_LOCKED       = locked;

	// Age of the result phase, kept apart from the phase counter
	logic [handler_pkg::CNT_W-1:0] sort_age, next_sort_age;

	always_comb begin
		next_sort_age = '0;
		if (phase == handler_pkg::SORT) begin
			next_sort_age = sort_age + 1'b1;
		end
	end

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			sort_age <= '0;
		end else begin
			sort_age <= next_sort_age;
		end
	end

	// Checks
	sequence s_start;
		phase == handler_pkg::IDLE && trig_rise;
	endsequence
	sequence s_busy_up;
		##1 meas_busy && !conv_busy;
	endsequence

	chk_trigger_starts_busy: assert property (
		@(posedge CLK) disable iff (!RST_B)
		s_start |-> s_busy_up)
		else $error("trigger edge did not raise measurement busy");

	chk_level_no_start: assert property (
		@(posedge CLK) disable iff (!RST_B)
		phase == handler_pkg::IDLE && !trig_rise |=> !meas_busy)
		else $error("busy rose without a trigger edge");

	chk_conv_in_meas: assert property (
		@(posedge CLK) disable iff (!RST_B)
		conv_busy |-> meas_busy)
		else $error("conversion busy outside measurement");

	chk_conv_end_calc: assert property (
		@(posedge CLK) disable iff (!RST_B)
		$fell(conv_busy) |-> phase == handler_pkg::CALC && meas_busy)
		else $error("conversion did not end into calculation");

	chk_busy_release: assert property (
		@(posedge CLK) disable iff (!RST_B)
		$fell(meas_busy) |->
			SORT_BIN_B == ~$past(VERDICT.bin_pass) &&
			PRIMARY_FAIL_B == !$past(VERDICT.primary_fail))
		else $error("busy released without fresh results");

	chk_result_hold: assert property (
		@(posedge CLK) disable iff (!RST_B)
		!$fell(meas_busy) |-> $stable(res))
		else $error("results changed while busy stayed");

	chk_result_delay: assert property (
		@(posedge CLK) disable iff (!RST_B)
		meas_busy |-> sort_age < handler_pkg::CNT_W'(RESULT_CYCLES))
		else $error("results not valid within result delay");

	chk_aux_gate: assert property (
		@(posedge CLK) disable iff (!RST_B)
		!$past(AUX_COMPARE_EN) && $fell(meas_busy) |-> SECONDARY_FAIL_B)
		else $error("secondary fail without auxiliary compare");

	chk_key_lock: assert property (
		@(posedge CLK) disable iff (!RST_B)
		$past(pins_s[0]) |-> !locked)
		else $error("keyboard locked while lock input high");

	chk_conv_start: assert property (
		@(posedge CLK) disable iff (!RST_B)
		conv_start |-> conv_busy && !$past(conv_busy))
		else $error("conversion start without conversion busy");
endmodule : handler_sort_trigger_port

`default_nettype wire

// File: design/handler_pkg.sv
package handler_pkg;

	// Sorting outputs
	localparam int NUM_BINS = 14;

	// Timing at the 10 MHz control clock
	localparam int CLK_PERIOD_NS = 100;
	localparam int TRIG_DELAY_NS = 5000;
	localparam int TRIG_DELAY_CYC = (TRIG_DELAY_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int CONV_TIME_US = 100;
	localparam int CONV_CYC = CONV_TIME_US * 1000 / CLK_PERIOD_NS;
	localparam int CALC_TIME_US = 1000;
	localparam int CALC_CYC = CALC_TIME_US * 1000 / CLK_PERIOD_NS;
	localparam int RESULT_DELAY_US = 200;
	localparam int RESULT_CYC = RESULT_DELAY_US * 1000 / CLK_PERIOD_NS;
	localparam int CNT_W = 16;

	// Reset values: active-low outputs idle high
	localparam logic [NUM_BINS-1:0] BIN_RESET = 14'h3fff;

	// Phases of one measurement cycle
	typedef enum logic [4:0] {
		IDLE  = 5'h01,
		DELAY = 5'h02,
		CONV  = 5'h04,
		CALC  = 5'h08,
		SORT  = 5'h10
	} phase_t;

	// Comparison verdict from the measurement core
	typedef struct packed {
		logic [NUM_BINS-1:0] bin_pass;
		logic                primary_fail;
		logic                secondary_fail;
		logic                above_limit;
		logic                below_limit;
	} verdict_t;

	// Active-low result pins
	typedef struct packed {
		logic [NUM_BINS-1:0] bin_b;
		logic                secondary_fail_b;
		logic                primary_fail_b;
		logic                above_b;
		logic                below_b;
		logic                fail_b;
	} result_pins_t;

endpackage : handler_pkg

// File: design/pin_sync.sv
`timescale 1ns/10ps
`default_nettype none

// Two-flop synchroniser for a group of pin inputs
module pin_sync #(
	parameter int WIDTH = 2
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             rst_b,
	// Pins and synchronised copy
	input  wire logic [WIDTH-1:0] din,
	output logic      [WIDTH-1:0] dout
);
	logic [WIDTH-1:0] meta;

	// Pins idle high (pulled up), so reset to ones
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			meta <= '1;
			dout <= '1;
		end else begin
			meta <= din;
			dout <= meta;
		end
	end
endmodule : pin_sync

`default_nettype wire

// File: tb/plc_model.sv
`timescale 1ns/10ps
`default_nettype none

// Handler controller: fires one trigger pulse per request
module plc_model #(
	parameter int PULSE_CYC = 10000
) (
	// Clock
	input  wire logic clk,
	// Trigger pin
	output logic      ext_trig
);
	initial ext_trig = 1'b0;

	// Pulse held for 1 ms at the 10 MHz clock
	task fire();
		@(posedge clk);
		ext_trig <= 1'b1;
		repeat (PULSE_CYC) @(posedge clk);
		ext_trig <= 1'b0;
		@(posedge clk);
	endtask : fire
endmodule : plc_model
`default_nettype wire

// File: tb/tb_top.sv
`timescale 1ns/10ps
`default_nettype none

module tb_top;
	localparam int CONV = 4;
	localparam int CALC = 4;
	localparam int RES  = 4;

	logic                                 clk;
	logic                                 rst_b;
	logic                                 key_lock_b;
	logic                                 aux_en;
	wire logic                            ext_trig;
	handler_pkg::verdict_t                verdict;
	handler_pkg::result_pins_t            pins;
	logic                                 conv_busy;
	logic                                 meas_busy;
	logic                                 kb_locked;
	logic                                 conv_start;
	int                                   num_errors = 0;
	int                                   n_tests = 0;

	handler_sort_trigger_port #(
		.CONV_CYCLES(CONV), .CALC_CYCLES(CALC), .RESULT_CYCLES(RES)
	) uut (
		.CLK(clk), .RST_B(rst_b), .EXT_TRIG(ext_trig),
		.KEY_LOCK_B(key_lock_b), .SORT_BIN_B(pins.bin_b),
		.SECONDARY_FAIL_B(pins.secondary_fail_b),
		.PRIMARY_FAIL_B(pins.primary_fail_b),
		.PRIMARY_ABOVE_LIMIT_B(pins.above_b),
		.PRIMARY_BELOW_LIMIT_B(pins.below_b),
		.OVERALL_FAIL_B(pins.fail_b), .CONVERSION_BUSY(conv_busy),
		.MEASUREMENT_BUSY(meas_busy), .VERDICT(verdict),
		.AUX_COMPARE_EN(aux_en), .KEYBOARD_LOCKED(kb_locked),
		.CONV_START(conv_start)
	);

	plc_model plc (.clk(clk), .ext_trig(ext_trig));

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task give_verdict();
		$display("errors %0d checks %0d", num_errors, n_tests);
		if (num_errors == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : give_verdict

	task tick();
		@(posedge clk);
		#1;
	endtask : tick

	// Outputs while idle after reset
	task test_idle();
		check({pins, conv_busy, meas_busy, kb_locked, conv_start},
			{19'h7ffff, 4'h0});
	endtask : test_idle

	// One full cycle: timing, then the result pins
	task test_meas(input logic [17:0] v, input logic aux);
		int n;
		handler_pkg::result_pins_t exp;
		@(posedge clk);
		verdict <= v;
		aux_en <= aux;
		fork plc.fire(); join_none
		n = 0;
		while (meas_busy !== 1'b1 && n < 20) begin tick(); n++; end
		check(n < 8, 1'b1);
		check(conv_busy, 1'b0);
		n = 0;
		while (conv_busy !== 1'b1 && n < 200) begin tick(); n++; end
		check(n, handler_pkg::TRIG_DELAY_CYC);
		check(conv_start, 1'b1);
		n = 0;
		while (conv_busy === 1'b1 && n < 200) begin tick(); n++; end
		check(n, CONV);
		check(meas_busy, 1'b1);
		n = 0;
		while (meas_busy === 1'b1 && n < 200) begin tick(); n++; end
		check(n, CALC + RES);
		exp.bin_b = ~verdict.bin_pass;
		exp.secondary_fail_b = ~(verdict.secondary_fail & aux);
		exp.primary_fail_b = ~verdict.primary_fail;
		exp.above_b = ~verdict.above_limit;
		exp.below_b = ~verdict.below_limit;
		exp.fail_b = ~(verdict.primary_fail | (verdict.secondary_fail & aux));
		check(pins, exp);
		repeat (50) tick();
		check({ext_trig, meas_busy}, 2'b10);
		wait fork;
	endtask : test_meas

	task test_lock();
		@(posedge clk);
		key_lock_b <= 1'b0;
		repeat (4) tick();
		check(kb_locked, 1'b1);
		@(posedge clk);
		key_lock_b <= 1'b1;
		repeat (4) tick();
		check(kb_locked, 1'b0);
	endtask : test_lock

	initial begin
		rst_b = 1'b0;
		key_lock_b = 1'b1;
		aux_en = 1'b0;
		verdict = '0;
		repeat (20) @(posedge clk);
		#1;
		test_idle();
		@(posedge clk);
		rst_b <= 1'b1;
		tick();
		test_idle();
		test_meas({14'h0001, 4'h0}, 1'b1);
		test_meas({14'h0000, 4'ha}, 1'b0);
		test_meas({14'h0000, 4'h5}, 1'b0);
		test_meas({14'h2000, 4'h4}, 1'b1);
		test_lock();
		give_verdict();
	end

	initial begin
		// Four measurements of about 10000 cycles each, plus margin
		repeat (60000) @(posedge clk);
		num_errors++;
		give_verdict();
	end
endmodule : tb_top
`default_nettype wire
